// ---- design/bse_exec_unit.v ----
// execution and sequencing unit for branch, skip and single-bit instructions
`timescale 1ns/1ps
`default_nettype none
`include "bse_regs.vh"

module bse_exec_unit (
    input  wire         clk,
    input  wire         rst,
    input  wire [5:0]   bus_addr,
    input  wire [7:0]   bus_wdata,
    input  wire         bus_we,
    input  wire         bus_re,
    output reg  [7:0]   bus_rdata_q,
    output reg  [15:0]  pm_addr_q,
    input  wire [15:0]  pm_rdata,
    input  wire [255:0] io_bits_in,
    output reg  [4:0]   io_addr_q,
    output reg  [7:0]   io_wdata_q,
    output reg          io_we_q,
    output reg  [15:0]  stk_addr_q,
    output reg  [7:0]   stk_wdata_q,
    output reg          stk_we_q
);

    localparam [2:0] ST_IDLE  = 3'd0;
    localparam [2:0] ST_WAIT  = 3'd1;
    localparam [2:0] ST_EXEC  = 3'd2;
    localparam [2:0] ST_SKIP  = 3'd3;
    localparam [2:0] ST_CALL2 = 3'd4;

    reg  [7:0]  rf_q [0:31];
    reg  [15:0] pc_q;
    reg  [15:0] pc_d;
    reg  [15:0] sp_q;
    reg  [15:0] sp_d;
    reg  [7:0]  flags_q;
    reg  [7:0]  flags_d;
    reg         run_q;
    reg  [2:0]  st_q;
    reg  [2:0]  st_d;
    reg         rf_we;
    reg  [4:0]  rf_waddr;
    reg  [7:0]  rf_wdata;
    reg  [4:0]  io_addr_d;
    reg  [7:0]  io_wdata_d;
    reg         io_we_d;
    reg  [15:0] stk_addr_d;
    reg  [7:0]  stk_wdata_d;
    reg         stk_we_d;
    reg  [7:0]  rd_mux;
    reg         flag_sel;

    // instruction fields
    wire [4:0]  op      = pm_rdata[`BSE_F_OP_HI:`BSE_F_OP_LO];
    wire [4:0]  f_rd    = pm_rdata[`BSE_F_RD_HI:`BSE_F_RD_LO];
    wire [4:0]  f_rr    = pm_rdata[`BSE_F_RR_HI:`BSE_F_RR_LO];
    wire [4:0]  f_sel   = pm_rdata[`BSE_F_SEL_HI:`BSE_F_SEL_LO];
    wire [2:0]  f_bit   = pm_rdata[`BSE_F_BIT_HI:`BSE_F_BIT_LO];
    wire [6:0]  f_k     = pm_rdata[`BSE_F_K_HI:`BSE_F_K_LO];
    wire [4:0]  f_crd   = {2'b10, pm_rdata[`BSE_F_CRD_HI:`BSE_F_CRD_LO]};
    wire [7:0]  f_imm   = pm_rdata[`BSE_F_IMM_HI:`BSE_F_IMM_LO];
    wire        f_slt   = pm_rdata[`BSE_F_SLT];

    // signed offset extension
    wire [15:0] k_ext   = {{9{f_k[6]}}, f_k};
    wire [15:0] br_tgt  = pc_q + k_ext + 16'h0001;
    wire [15:0] ptr_z   = {rf_q[5'd31], rf_q[5'd30]};
    wire [15:0] ret_adr = pc_q + 16'h0001;
    // memory answers one cycle late, so fetch runs one word ahead while executing
    wire [15:0] fetch_adr = (st_d == ST_EXEC || st_d == ST_SKIP) ? pc_d + 16'h0001 : pc_d;

    wire [7:0]  r_a     = rf_q[f_rd];
    wire [7:0]  r_b     = rf_q[f_rr];
    wire [7:0]  r_sel   = rf_q[f_sel];
    wire [7:0]  io_byte = io_bits_in[{f_sel, 3'b000} +: 8];

    // compare with constant
    wire [7:0]  c_rd    = rf_q[f_crd];
    wire [7:0]  c_res   = c_rd - f_imm;
    wire        c_h     = (~c_rd[3] & f_imm[3]) | (f_imm[3] & c_res[3]) | (c_res[3] & ~c_rd[3]);
    wire        c_v     = (c_rd[7] & ~f_imm[7] & ~c_res[7]) | (~c_rd[7] & f_imm[7] & c_res[7]);
    wire        c_c     = (~c_rd[7] & f_imm[7]) | (f_imm[7] & c_res[7]) | (c_res[7] & ~c_rd[7]);

    // rotate left through carry
    wire [7:0]  rot_in  = rf_q[f_rr];
    wire [7:0]  rot_res = {rot_in[6:0], flags_q[`BSE_FLAG_C]};
    wire        rot_c   = rot_in[7];
    wire        rot_n   = rot_res[7];
    wire        rot_v   = rot_n ^ rot_c;

    wire        bus_in_rf = (bus_addr[5] == 1'b1);
    wire        sign_nv   = flags_q[`BSE_FLAG_N] ^ flags_q[`BSE_FLAG_V];

    // selected status flag; named branches are aliases through the selector
    always @*
    begin
        flag_sel = flags_q[f_bit];
    end

    // sequencer
    always @*
    begin
        pc_d        = pc_q;
        sp_d        = sp_q;
        st_d        = st_q;
        flags_d     = flags_q;
        rf_we       = 1'b0;
        rf_waddr    = f_rr;
        rf_wdata    = rot_res;
        io_addr_d   = io_addr_q;
        io_wdata_d  = io_wdata_q;
        io_we_d     = 1'b0;
        stk_addr_d  = stk_addr_q;
        stk_wdata_d = stk_wdata_q;
        stk_we_d    = 1'b0;
        if (bus_we && bus_addr == `BSE_OFF_FLAGS)
        begin
            flags_d = bus_wdata;
        end
        case (st_q)
            ST_IDLE:
            begin
                if (bus_we && bus_addr == `BSE_OFF_PC_LO)
                begin
                    pc_d = {pc_q[15:8], bus_wdata};
                end
                if (bus_we && bus_addr == `BSE_OFF_PC_HI)
                begin
                    pc_d = {bus_wdata, pc_q[7:0]};
                end
                if (bus_we && bus_addr == `BSE_OFF_SP_LO)
                begin
                    sp_d = {sp_q[15:8], bus_wdata};
                end
                if (bus_we && bus_addr == `BSE_OFF_SP_HI)
                begin
                    sp_d = {bus_wdata, sp_q[7:0]};
                end
                if (run_q)
                begin
                    st_d = ST_WAIT;
                end
            end
            ST_WAIT:
            begin
                st_d = ST_EXEC;
            end
            ST_CALL2:
            begin
                stk_we_d    = 1'b1;
                stk_addr_d  = sp_q;
                stk_wdata_d = ret_adr[15:8];
                sp_d        = sp_q - 16'h0001;
                pc_d        = ptr_z;
                st_d        = ST_WAIT;
            end
            ST_SKIP:
            begin
                // word at pc_q is the one being skipped
                if (op == `BSE_OP_LONG)
                begin
                    pc_d = pc_q + 16'h0002;
                    st_d = ST_WAIT;
                end
                else
                begin
                    pc_d = pc_q + 16'h0001;
                    st_d = ST_EXEC;
                end
            end
            ST_EXEC:
            begin
                pc_d = pc_q + 16'h0001;
                if (!run_q)
                begin
                    pc_d = pc_q;
                    st_d = ST_IDLE;
                end
                else
                begin
                    case (op)
                        `BSE_OP_PTR_JUMP:
                        begin
                            pc_d = ptr_z;
                            st_d = ST_WAIT;
                        end
                        `BSE_OP_PTR_CALL:
                        begin
                            stk_we_d    = 1'b1;
                            stk_addr_d  = sp_q;
                            stk_wdata_d = ret_adr[7:0];
                            sp_d        = sp_q - 16'h0001;
                            pc_d        = pc_q;
                            st_d        = ST_CALL2;
                        end
                        `BSE_OP_CMP_SKIP:
                        begin
                            if (r_a == r_b)
                            begin
                                st_d = ST_SKIP;
                            end
                        end
                        `BSE_OP_CMP_CONST:
                        begin
                            flags_d[`BSE_FLAG_Z] = (c_res == 8'h00);
                            flags_d[`BSE_FLAG_N] = c_res[7];
                            flags_d[`BSE_FLAG_V] = c_v;
                            flags_d[`BSE_FLAG_C] = c_c;
                            flags_d[`BSE_FLAG_H] = c_h;
                            flags_d[`BSE_FLAG_S] = c_res[7] ^ c_v;
                        end
                        `BSE_OP_RBIT_LOW:
                        begin
                            if (!r_sel[f_bit])
                            begin
                                st_d = ST_SKIP;
                            end
                        end
                        `BSE_OP_RBIT_HIGH:
                        begin
                            if (r_sel[f_bit])
                            begin
                                st_d = ST_SKIP;
                            end
                        end
                        `BSE_OP_IOBIT_LOW:
                        begin
                            if (!io_byte[f_bit])
                            begin
                                st_d = ST_SKIP;
                            end
                        end
                        `BSE_OP_IOBIT_HIGH:
                        begin
                            if (io_byte[f_bit])
                            begin
                                st_d = ST_SKIP;
                            end
                        end
                        `BSE_OP_IO_FORCE_H:
                        begin
                            io_we_d    = 1'b1;
                            io_addr_d  = f_sel;
                            io_wdata_d = io_byte | (8'h01 << f_bit);
                            st_d       = ST_WAIT;
                        end
                        `BSE_OP_IO_FORCE_L:
                        begin
                            io_we_d    = 1'b1;
                            io_addr_d  = f_sel;
                            io_wdata_d = io_byte & ~(8'h01 << f_bit);
                            st_d       = ST_WAIT;
                        end
                        `BSE_OP_FLAG_HIGH:
                        begin
                            if (flag_sel)
                            begin
                                pc_d = br_tgt;
                                st_d = ST_WAIT;
                            end
                        end
                        `BSE_OP_FLAG_LOW:
                        begin
                            if (!flag_sel)
                            begin
                                pc_d = br_tgt;
                                st_d = ST_WAIT;
                            end
                        end
                        `BSE_OP_SIGNED_BR:
                        begin
                            if (sign_nv == f_slt)
                            begin
                                pc_d = br_tgt;
                                st_d = ST_WAIT;
                            end
                        end
                        `BSE_OP_ROTATE_L:
                        begin
                            rf_we                = 1'b1;
                            flags_d[`BSE_FLAG_Z] = (rot_res == 8'h00);
                            flags_d[`BSE_FLAG_C] = rot_c;
                            flags_d[`BSE_FLAG_N] = rot_n;
                            flags_d[`BSE_FLAG_V] = rot_v;
                            flags_d[`BSE_FLAG_S] = rot_n ^ rot_v;
                        end
                        `BSE_OP_LONG:
                        begin
                            pc_d = pc_q + 16'h0002;
                            st_d = ST_WAIT;
                        end
                        default:
                        begin
                            pc_d = pc_q + 16'h0001;
                        end
                    endcase
                end
            end
            default:
            begin
                st_d = ST_IDLE;
            end
        endcase
    end

    // state, program counter and port registers
    always @(posedge clk)
    begin
        if (rst)
        begin
            st_q        <= ST_IDLE;
            pc_q        <= `BSE_RST_PC;
            sp_q        <= `BSE_RST_SP;
            flags_q     <= `BSE_RST_FLAGS;
            run_q       <= 1'b0;
            pm_addr_q   <= `BSE_RST_PC;
            io_addr_q   <= 5'h00;
            io_wdata_q  <= 8'h00;
            io_we_q     <= 1'b0;
            stk_addr_q  <= 16'h0000;
            stk_wdata_q <= 8'h00;
            stk_we_q    <= 1'b0;
        end
        else
        begin
            st_q        <= st_d;
            pc_q        <= pc_d;
            sp_q        <= sp_d;
            flags_q     <= flags_d;
            pm_addr_q   <= fetch_adr;
            io_addr_q   <= io_addr_d;
            io_wdata_q  <= io_wdata_d;
            io_we_q     <= io_we_d;
            stk_addr_q  <= stk_addr_d;
            stk_wdata_q <= stk_wdata_d;
            stk_we_q    <= stk_we_d;
            if (bus_we && bus_addr == `BSE_OFF_CTRL)
            begin
                run_q <= bus_wdata[`BSE_CTRL_RUN];
            end
        end
    end

    // working registers; core write lands after a same-cycle bus write
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi = gi + 1)
        begin : g_rf
            always @(posedge clk)
            begin
                if (rst)
                begin
                    rf_q[gi] <= `BSE_RST_RF;
                end
                else if (rf_we && rf_waddr == gi)
                begin
                    rf_q[gi] <= rf_wdata;
                end
                else if (bus_we && bus_in_rf && bus_addr[4:0] == gi)
                begin
                    rf_q[gi] <= bus_wdata;
                end
            end
        end
    endgenerate

    // register port read data
    always @*
    begin
        rd_mux = 8'h00;
        if (bus_in_rf)
        begin
            rd_mux = rf_q[bus_addr[4:0]];
        end
        else
        begin
            case (bus_addr)
                `BSE_OFF_CTRL:  rd_mux = {7'h00, run_q};
                `BSE_OFF_FLAGS: rd_mux = flags_q;
                `BSE_OFF_PC_LO: rd_mux = pc_q[7:0];
                `BSE_OFF_PC_HI: rd_mux = pc_q[15:8];
                `BSE_OFF_SP_LO: rd_mux = sp_q[7:0];
                `BSE_OFF_SP_HI: rd_mux = sp_q[15:8];
                `BSE_OFF_STATE: rd_mux = {5'h00, st_q};
                default:        rd_mux = 8'h00;
            endcase
        end
    end

    always @(posedge clk)
    begin
        if (rst)
        begin
            bus_rdata_q <= 8'h00;
        end
        else if (bus_re)
        begin
            bus_rdata_q <= rd_mux;
        end
        else
        begin
            bus_rdata_q <= 8'h00;
        end
    end

endmodule
`default_nettype wire

// ---- design/bse_regs.vh ----
// constants for the branch, skip and bit-operation execution unit
`ifndef BSE_REGS_VH
`define BSE_REGS_VH

// register port offsets (6-bit address, 8-bit data)
`define BSE_ADDR_W        6
`define BSE_OFF_CTRL      6'h00
`define BSE_OFF_FLAGS     6'h01
`define BSE_OFF_PC_LO     6'h02
`define BSE_OFF_PC_HI     6'h03
`define BSE_OFF_SP_LO     6'h04
`define BSE_OFF_SP_HI     6'h05
`define BSE_OFF_STATE     6'h06
`define BSE_OFF_RF_BASE   6'h20

// control register fields
`define BSE_CTRL_RUN      0

// reset values
`define BSE_RST_CTRL      8'h00
`define BSE_RST_FLAGS     8'h00
`define BSE_RST_PC        16'h0000
`define BSE_RST_SP        16'h00FF
`define BSE_RST_RF        8'h00

// status flag positions
`define BSE_FLAG_C        0
`define BSE_FLAG_Z        1
`define BSE_FLAG_N        2
`define BSE_FLAG_V        3
`define BSE_FLAG_S        4
`define BSE_FLAG_H        5
`define BSE_FLAG_T        6
`define BSE_FLAG_I        7

// instruction word fields
`define BSE_F_OP_HI       15
`define BSE_F_OP_LO       11
`define BSE_F_RD_HI       9
`define BSE_F_RD_LO       5
`define BSE_F_RR_HI       4
`define BSE_F_RR_LO       0
`define BSE_F_SEL_HI      7
`define BSE_F_SEL_LO      3
`define BSE_F_BIT_HI      2
`define BSE_F_BIT_LO      0
`define BSE_F_K_HI        9
`define BSE_F_K_LO        3
`define BSE_F_CRD_HI      10
`define BSE_F_CRD_LO      8
`define BSE_F_IMM_HI      7
`define BSE_F_IMM_LO      0
`define BSE_F_SLT         10

// opcodes
`define BSE_OP_PTR_JUMP   5'h01
`define BSE_OP_PTR_CALL   5'h02
`define BSE_OP_CMP_SKIP   5'h03
`define BSE_OP_CMP_CONST  5'h04
`define BSE_OP_RBIT_LOW   5'h05
`define BSE_OP_RBIT_HIGH  5'h06
`define BSE_OP_IOBIT_LOW  5'h07
`define BSE_OP_IOBIT_HIGH 5'h08
`define BSE_OP_IO_FORCE_H 5'h09
`define BSE_OP_IO_FORCE_L 5'h0A
`define BSE_OP_FLAG_HIGH  5'h0B
`define BSE_OP_FLAG_LOW   5'h0C
`define BSE_OP_ROTATE_L   5'h0D
`define BSE_OP_SIGNED_BR  5'h0E
`define BSE_OP_LONG       5'h1F

`endif

// ---- sim/bse_exec_unit_props.sv ----
// port-level assertions for the execution unit
`timescale 1ns/1ps
`default_nettype none
`include "bse_regs.vh"
module bse_exec_props (
    input wire logic         clk,
    input wire logic         rst,
    input wire logic [5:0]   bus_addr,
    input wire logic [7:0]   bus_wdata,
    input wire logic         bus_we,
    input wire logic         bus_re,
    input wire logic [7:0]   bus_rdata_q,
    input wire logic [15:0]  pm_addr_q,
    input wire logic [15:0]  pm_rdata,
    input wire logic [255:0] io_bits_in,
    input wire logic [4:0]   io_addr_q,
    input wire logic [7:0]   io_wdata_q,
    input wire logic         io_we_q,
    input wire logic [15:0]  stk_addr_q,
    input wire logic [7:0]   stk_wdata_q,
    input wire logic         stk_we_q
);
    logic [7:0]  flg_q;
    logic        dirty_q;
    logic [15:0] ptr_q;
    logic        flg_op;
    logic        flg_wr;
    assign flg_op = pm_rdata[15:11] == `BSE_OP_CMP_CONST || pm_rdata[15:11] == `BSE_OP_ROTATE_L;
    assign flg_wr = bus_we && bus_addr == `BSE_OFF_FLAGS;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // shadow of software-written flags and pointer pair
    always @(posedge clk)
    begin
        if (rst)
        begin
            flg_q   <= 8'h00;
            dirty_q <= 1'b0;
            ptr_q   <= 16'h0000;
        end
        else
        begin
            if (flg_wr)
                flg_q <= bus_wdata;
            if (bus_we && bus_addr == 6'h3E)
                ptr_q[7:0] <= bus_wdata;
            if (bus_we && bus_addr == 6'h3F)
                ptr_q[15:8] <= bus_wdata;
            dirty_q <= flg_op || (dirty_q && !flg_wr);
        end
    end
    AST_IO_FORCE_HI: assert property (io_we_q && $past(pm_rdata[15:11]) == `BSE_OP_IO_FORCE_H
        |-> io_wdata_q[$past(pm_rdata[2:0])] == 1'b1 && io_addr_q == $past(pm_rdata[7:3]))
        else $error("forced-high bit or address wrong");
    AST_IO_FORCE_LO: assert property (io_we_q && $past(pm_rdata[15:11]) == `BSE_OP_IO_FORCE_L
        |-> io_wdata_q[$past(pm_rdata[2:0])] == 1'b0 && io_addr_q == $past(pm_rdata[7:3]))
        else $error("forced-low bit or address wrong");
    AST_IO_KEEP: assert property (io_we_q |->
        ((io_wdata_q ^ io_bits_in[{io_addr_q, 3'b000} +: 8]) & ~(8'h01 << $past(pm_rdata[2:0])))
        == 8'h00) else $error("other I/O bits changed");
    AST_IO_SINGLE: assert property (io_we_q |=> !io_we_q)
        else $error("I/O write longer than one cycle");
    AST_PUSH_PAIR: assert property ($rose(stk_we_q) |=> stk_we_q &&
        stk_addr_q == $past(stk_addr_q) - 16'h0001) else $error("second push missing");
    AST_PUSH_END: assert property (stk_we_q ##1 stk_we_q |=> !stk_we_q)
        else $error("more than two pushes");
    AST_PUSH_CAUSE: assert property ($rose(stk_we_q) |->
        $past(pm_rdata[15:11]) == `BSE_OP_PTR_CALL) else $error("push without call");
    AST_CALL_TARGET: assert property (stk_we_q && $past(stk_we_q) |-> pm_addr_q == ptr_q)
        else $error("call target wrong");
    AST_FLAGS_KEPT: assert property (bus_re && bus_addr == `BSE_OFF_FLAGS && !dirty_q &&
        !flg_op |=> bus_rdata_q == $past(flg_q)) else $error("flags changed");
endmodule
bind bse_exec_unit bse_exec_props u_props (
    .clk(clk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_we(bus_we),
    .bus_re(bus_re), .bus_rdata_q(bus_rdata_q), .pm_addr_q(pm_addr_q), .pm_rdata(pm_rdata),
    .io_bits_in(io_bits_in), .io_addr_q(io_addr_q), .io_wdata_q(io_wdata_q),
    .io_we_q(io_we_q), .stk_addr_q(stk_addr_q), .stk_wdata_q(stk_wdata_q),
    .stk_we_q(stk_we_q)
);
`default_nettype wire

// ---- sim/bse_mem_model.sv ----
// program memory, I/O space and stack memory facing the execution unit
`timescale 1ns/1ps
`default_nettype none
module bse_mem_model (
    input  wire logic         clk,
    input  wire logic [15:0]  pm_addr_q,
    output var  logic [15:0]  pm_rdata,
    output wire logic [255:0] io_bits_in,
    input  wire logic [4:0]   io_addr_q,
    input  wire logic [7:0]   io_wdata_q,
    input  wire logic         io_we_q,
    input  wire logic [15:0]  stk_addr_q,
    input  wire logic [7:0]   stk_wdata_q,
    input  wire logic         stk_we_q
);
    logic [15:0] mem_q [0:255];
    logic [7:0]  io_q  [0:31];
    logic [7:0]  stk_q [0:255];
    initial pm_rdata = 16'h0000;
    for (genvar g = 0; g < 32; g++)
    begin : g_io
        assign io_bits_in[8*g +: 8] = io_q[g];
    end
    // synchronous memory answers every cycle
    always @(posedge clk)
    begin
        pm_rdata <= mem_q[pm_addr_q[7:0]];
        if (io_we_q)
            io_q[io_addr_q] <= io_wdata_q;
        if (stk_we_q)
            stk_q[stk_addr_q[7:0]] <= stk_wdata_q;
    end
endmodule
`default_nettype wire

// ---- sim/tb.sv ----
// self-checking testbench for the execution unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module tb;
    logic         clk;
    logic         rst;
    logic [5:0]   bus_addr;
    logic [7:0]   bus_wdata;
    logic         bus_we;
    logic         bus_re;
    logic [7:0]   bus_rdata_q;
    logic [15:0]  pm_addr_q;
    logic [15:0]  pm_rdata;
    logic [255:0] io_bits_in;
    logic [4:0]   io_addr_q;
    logic [7:0]   io_wdata_q;
    logic         io_we_q;
    logic [15:0]  stk_addr_q;
    logic [7:0]   stk_wdata_q;
    logic         stk_we_q;
    logic [7:0]   fl;
    int           failures;
    int           tests_run;
    bse_exec_unit dut (
        .clk(clk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_we(bus_we),
        .bus_re(bus_re), .bus_rdata_q(bus_rdata_q), .pm_addr_q(pm_addr_q), .pm_rdata(pm_rdata),
        .io_bits_in(io_bits_in), .io_addr_q(io_addr_q), .io_wdata_q(io_wdata_q),
        .io_we_q(io_we_q), .stk_addr_q(stk_addr_q), .stk_wdata_q(stk_wdata_q),
        .stk_we_q(stk_we_q)
    );
    bse_mem_model pm (
        .clk(clk), .pm_addr_q(pm_addr_q), .pm_rdata(pm_rdata), .io_bits_in(io_bits_in),
        .io_addr_q(io_addr_q), .io_wdata_q(io_wdata_q), .io_we_q(io_we_q),
        .stk_addr_q(stk_addr_q), .stk_wdata_q(stk_wdata_q), .stk_we_q(stk_we_q)
    );
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic test_done;
        if (failures == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_addr  <= a;
        bus_wdata <= d;
        bus_we    <= 1'b1;
        @(posedge clk);
        bus_we    <= 1'b0;
    endtask
    task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
        @(posedge clk);
        bus_addr <= a;
        bus_re   <= 1'b1;
        @(posedge clk);
        bus_re   <= 1'b0;
        #1;
        `CHK(bus_rdata_q, e)
    endtask
    // instruction at 0x10, markers set bits of I/O byte 2, every other word jumps to 0xF0
    task automatic run_case(input logic [7:0] f, input logic [15:0] ins, vic,
                            input logic [7:0] io0, eio, ef);
        for (int i = 0; i < 256; i++)
            pm.mem_q[i] = 16'h0800;
        pm.mem_q[8'h10] = ins;
        pm.mem_q[8'h11] = vic;
        pm.mem_q[8'h12] = 16'h4811;
        pm.mem_q[8'h13] = 16'h4812;
        pm.mem_q[8'h09] = 16'h4813;
        pm.io_q[2] = io0;
        wr(6'h01, f);
        wr(6'h02, 8'h10);
        wr(6'h03, 8'h00);
        wr(6'h00, 8'h01);
        repeat (40) @(posedge clk);
        wr(6'h00, 8'h00);
        repeat (4) @(posedge clk);
        `CHK(pm.io_q[2], eio)
        rd_chk(6'h01, ef);
        rd_chk(6'h02, 8'hF0);
    endtask
    task automatic go(input logic [7:0] f, input logic [15:0] ins, input logic [7:0] eio);
        run_case(f, ins, 16'h4810, 8'h00, eio, f);
    endtask
    initial
    begin
        rst = 1'b1;
        bus_addr = 6'h00;
        bus_wdata = 8'h00;
        bus_we = 1'b0;
        bus_re = 1'b0;
        failures = 0;
        tests_run = 0;
        for (int i = 0; i < 256; i++)
            pm.mem_q[i] = 16'h0800;
        for (int i = 0; i < 32; i++)
            pm.io_q[i] = 8'h00;
        pm.io_q[3] = 8'h5A;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd_chk(6'h01, 8'h00);
        rd_chk(6'h04, 8'hFF);
        rd_chk(6'h02, 8'h00);
        rd_chk(6'h10, 8'h00);
        wr(6'h3E, 8'hF0);
        wr(6'h3F, 8'h00);
        wr(6'h25, 8'h5A);
        wr(6'h26, 8'h5A);
        wr(6'h30, 8'h10);
        wr(6'h28, 8'h81);
        go(8'hA5, 16'h0800, 8'h00);
        go(8'hA5, 16'h2828, 8'h06);
        go(8'hA5, 16'h2829, 8'h07);
        go(8'hA5, 16'h3029, 8'h06);
        go(8'hA5, 16'h3028, 8'h07);
        go(8'hA5, 16'h3818, 8'h06);
        go(8'hA5, 16'h3819, 8'h07);
        go(8'hA5, 16'h4019, 8'h06);
        go(8'hA5, 16'h4018, 8'h07);
        go(8'hA5, 16'h18A6, 8'h06);
        go(8'hA5, 16'h18A7, 8'h07);
        run_case(8'hA5, 16'h2828, 16'hF800, 8'h00, 8'h04, 8'hA5);
        for (int s = 0; s < 8; s++)
        begin
            fl = 8'h01 << s;
            go(fl, {5'h0B, 1'b0, 7'h02, s[2:0]}, 8'h04);
            go(fl, {5'h0C, 1'b0, 7'h02, s[2:0]}, 8'h07);
            go(~fl, {5'h0B, 1'b0, 7'h02, s[2:0]}, 8'h07);
            go(~fl, {5'h0C, 1'b0, 7'h02, s[2:0]}, 8'h04);
        end
        go(8'h00, {5'h0C, 1'b0, 7'h78, 3'd0}, 8'h08);
        go(8'h04, {5'h0E, 1'b1, 7'h02, 3'd0}, 8'h04);
        go(8'h04, {5'h0E, 1'b0, 7'h02, 3'd0}, 8'h07);
        go(8'h0C, {5'h0E, 1'b0, 7'h02, 3'd0}, 8'h04);
        go(8'h0C, {5'h0E, 1'b1, 7'h02, 3'd0}, 8'h07);
        go(8'h08, {5'h0E, 1'b1, 7'h02, 3'd0}, 8'h04);
        run_case(8'h00, 16'h4814, 16'h0800, 8'hA5, 8'hB5, 8'h00);
        run_case(8'h00, 16'h5014, 16'h0800, 8'hFF, 8'hEF, 8'h00);
        run_case(8'h00, 16'h2020, 16'h0800, 8'h00, 8'h00, 8'h15);
        rd_chk(6'h30, 8'h10);
        run_case(8'h21, 16'h6808, 16'h0800, 8'h00, 8'h00, 8'h39);
        rd_chk(6'h28, 8'h03);
        run_case(8'h00, 16'h1000, 16'h4810, 8'h00, 8'h00, 8'h00);
        `CHK(pm.stk_q[8'hFF], 8'h11)
        `CHK(pm.stk_q[8'hFE], 8'h00)
        rd_chk(6'h04, 8'hFD);
        test_done;
    end
    initial
    begin
        repeat (10000) @(posedge clk);
        failures++;
        test_done;
    end
endmodule
`default_nettype wire
